// ---- hw/ptd_pkg.sv ----
// Constants for the bus phase decoder front end.
// Assumes all bus pins are sampled synchronous to sys_clk.
// Contract
// - Address phase, then at least one data phase
// - First FRAME low cycle is address phase (the code ignores a FRAME low in the turnaround cycle after the last transfer)
// - Data phase completes only when both ready low
// - Shared lines demuxed into address or data
// - Address phase command: 0000 ack, 0001 special
// - Data phase lanes: bit0 LSB, bit3 MSB
package ptd_pkg;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam logic [3:0] CMD_INT_ACK = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [3:0] BE_RST = 4'h0;
    localparam logic [3:0] CMD_RST = 4'hf;

    typedef enum logic [1:0] {PTD_IDLE, PTD_DATA, PTD_TURN} ptd_state_e;
endpackage : ptd_pkg

// ---- hw/ptd_phase_decode.sv ----
// Bus phase decoder: splits the shared lines into address, command,
// data and byte lanes. Assumes a well-behaved initiator on the far side.
`timescale 1ns/10ps
module ptd_phase_decode #(
    parameter int AD_W = ptd_pkg::AD_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Bus side
    input wire logic [AD_W-1:0] ad_in,
    input wire logic [3:0] cbe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    // User side
    output logic addr_phase,
    output logic [AD_W-1:0] addr,
    output logic [3:0] cmd,
    output logic is_int_ack,
    output logic is_special,
    output logic data_valid,
    output logic [AD_W-1:0] data,
    output logic [3:0] byte_en,
    output logic in_txn
);
    // Four lane enables only cover a 32-bit word; wider lines need a new lane map
    if (AD_W != 32) begin : g_bad_width
        $error("ptd_phase_decode serves only 32-bit lines");
    end

    // Both ready lines low: the only cycles that move a word
    function automatic logic both_ready(input logic rdy_a_n, input logic rdy_b_n);
        return ~rdy_a_n & ~rdy_b_n;
    endfunction : both_ready

    // Lane enables arrive active low; users see them active high
    function automatic logic [3:0] lanes_on(input logic [3:0] be_n);
        return ~be_n;
    endfunction : lanes_on

    typedef struct packed {
        ptd_pkg::ptd_state_e st;
        logic addr_phase;
        logic [AD_W-1:0] addr;
        logic [3:0] cmd;
        logic data_valid;
        logic [AD_W-1:0] data;
        logic [3:0] byte_en;
        logic int_ack;
        logic special;
    } ptd_s;

    // Whole state in one register; next_r is its next value
    ptd_s r;
    ptd_s next_r;

    logic frame_act;
    logic xfer;
    assign frame_act = ~frame_n;
    assign xfer = both_ready(irdy_n, trdy_n);

    always_comb begin
        next_r = r;
        next_r.addr_phase = 1'b0;
        next_r.data_valid = 1'b0;
        case (r.st)
            ptd_pkg::PTD_IDLE: begin
                if (frame_act) begin
                    next_r.st = ptd_pkg::PTD_DATA;
                    next_r.addr_phase = 1'b1;
                    next_r.addr = ad_in;
                    next_r.cmd = cbe_n;
                    // Decoded here so the flags leave straight from flip-flops
                    next_r.int_ack = (cbe_n == ptd_pkg::CMD_INT_ACK);
                    next_r.special = (cbe_n == ptd_pkg::CMD_SPECIAL);
                end
            end
            ptd_pkg::PTD_DATA: begin
                // Wait cycles (either ready high) pass with nothing captured
                if (xfer) begin
                    next_r.data_valid = 1'b1;
                    next_r.data = ad_in;
                    next_r.byte_en = lanes_on(cbe_n);
                end
                // Last phase: FRAME released, wait for the final transfer
                if (!frame_act && xfer) begin
                    next_r.st = ptd_pkg::PTD_TURN;
                end
            end
            ptd_pkg::PTD_TURN: begin
                // One idle cycle so a back-to-back FRAME is not taken as data
                next_r.st = ptd_pkg::PTD_IDLE;
            end
            default: next_r.st = ptd_pkg::PTD_IDLE;
        endcase
    end

    // Reset wins over the enable so a frozen block still clears
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r.st <= ptd_pkg::PTD_IDLE;
            r.addr_phase <= 1'b0;
            r.addr <= ptd_pkg::ADDR_RST;
            r.cmd <= ptd_pkg::CMD_RST;
            r.data_valid <= 1'b0;
            r.data <= ptd_pkg::DATA_RST;
            r.byte_en <= ptd_pkg::BE_RST;
            r.int_ack <= (ptd_pkg::CMD_RST == ptd_pkg::CMD_INT_ACK);
            r.special <= (ptd_pkg::CMD_RST == ptd_pkg::CMD_SPECIAL);
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // Pulses and words all leave straight from the state register
    assign addr_phase = r.addr_phase;
    assign addr = r.addr;
    assign cmd = r.cmd;
    assign is_int_ack = r.int_ack;
    assign is_special = r.special;
    assign data_valid = r.data_valid;
    assign data = r.data;
    assign byte_en = r.byte_en;
    assign in_txn = (r.st == ptd_pkg::PTD_DATA);

    property p_addr_capture;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && r.st == ptd_pkg::PTD_IDLE && !frame_n)
            |=> (addr_phase && addr == $past(ad_in) && cmd == $past(cbe_n));
    endproperty
    a_addr_capture: assert property (p_addr_capture) else $error("address not captured");

    // A frozen pulse stays up, so only fresh ones are traced back
    property p_data_only_on_xfer;
        @(posedge sys_clk) disable iff (rst)
        data_valid && $past(clk_en) |-> $past(in_txn && both_ready(irdy_n, trdy_n));
    endproperty
    a_data_only_on_xfer: assert property (p_data_only_on_xfer) else $error("bad data");

    property p_data_capture;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && in_txn && !irdy_n && !trdy_n)
            |=> (data_valid && data == $past(ad_in));
    endproperty
    a_data_capture: assert property (p_data_capture) else $error("data lost");

    property p_lanes;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && in_txn && !irdy_n && !trdy_n) |=> byte_en == ~$past(cbe_n);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane map wrong");

    // Flags must match the code on the lines at the capture edge
    property p_cmd_decode;
        @(posedge sys_clk) disable iff (rst)
        addr_phase && $past(clk_en)
            |-> (is_int_ack == ($past(cbe_n) == 4'h0))
            && (is_special == ($past(cbe_n) == 4'h1));
    endproperty
    a_cmd_decode: assert property (p_cmd_decode) else $error("command decode wrong");

    // One pulse per address phase, then a data-phase cycle follows
    property p_addr_then_data;
        @(posedge sys_clk) disable iff (rst)
        addr_phase && clk_en |-> in_txn && !data_valid ##1 !addr_phase;
    endproperty
    a_addr_then_data: assert property (p_addr_then_data) else $error("phase order");

    // Outside a transaction no word may be reported
    property p_no_data_idle;
        @(posedge sys_clk) disable iff (rst)
        $past(!in_txn && clk_en) |-> !data_valid;
    endproperty
    a_no_data_idle: assert property (p_no_data_idle) else $error("data outside txn");

    // Enable low must hold every bit of state, pulses included
    property p_freeze;
        @(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    // No frame, no address phase
    property p_idle_quiet;
        @(posedge sys_clk) disable iff (rst)
        clk_en && r.st == ptd_pkg::PTD_IDLE && frame_n |=> !addr_phase && !in_txn;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("phase without frame");

    // A frame raised during turnaround belongs to no transaction
    property p_turn_refuse;
        @(posedge sys_clk) disable iff (rst)
        clk_en && r.st == ptd_pkg::PTD_TURN |=> !addr_phase && !in_txn && !data_valid;
    endproperty
    a_turn_refuse: assert property (p_turn_refuse) else $error("turnaround not idle");

    // Wait cycles keep the transaction open and report nothing
    property p_wait_hold;
        @(posedge sys_clk) disable iff (rst)
        clk_en && in_txn && !both_ready(irdy_n, trdy_n) |=> in_txn && !data_valid;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait cycle moved data");

    // A transfer with the frame released is the last one
    property p_end_on_last;
        @(posedge sys_clk) disable iff (rst)
        clk_en && in_txn && frame_n && both_ready(irdy_n, trdy_n) |=> !in_txn;
    endproperty
    a_end_on_last: assert property (p_end_on_last) else $error("last phase missed");

    // Captured words stay put until the next capture
    property p_addr_hold;
        @(posedge sys_clk) disable iff (rst)
        clk_en && !(r.st == ptd_pkg::PTD_IDLE && !frame_n) |=> $stable(addr) && $stable(cmd);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed");

    property p_data_hold;
        @(posedge sys_clk) disable iff (rst)
        clk_en && !(in_txn && both_ready(irdy_n, trdy_n))
            |=> $stable(data) && $stable(byte_en);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data changed");
endmodule : ptd_phase_decode

// ---- tb/ptd_master.sv ----
// Initiator model: one-word transactions on the shared bus lines.
// Assumes the caller enters each task just after a falling edge.
`timescale 1ns/10ps
module ptd_master (
    // Clock
    input wire logic sys_clk,
    // Bus lines
    output logic [31:0] ad,
    output logic [3:0] cbe_n,
    output logic frame_n,
    output logic irdy_n,
    output logic trdy_n
);
    initial begin
        ad = 32'h0;
        cbe_n = 4'hf;
        {frame_n, irdy_n, trdy_n} = 3'b111;
    end
    task automatic addr_ph(input logic [31:0] a, input logic [3:0] c);
        @(negedge sys_clk);
        frame_n = 1'b1;
        @(negedge sys_clk);
        frame_n = 1'b0;
        ad = a;
        cbe_n = c;
        @(negedge sys_clk);
    endtask : addr_ph
    task automatic data_ph(input logic [31:0] d, input logic [3:0] be, input int w, bit early);
        {frame_n, irdy_n} = 2'b10;
        ad = d;
        cbe_n = be;
        repeat (w) @(negedge sys_clk);
        trdy_n = 1'b0;
        @(negedge sys_clk);
        // Released lines: IRDY and TRDY float high, FRAME low again when early, data inverted so nothing stale passes
        {frame_n, irdy_n, trdy_n} = {!early, 2'b11};
        ad = ~d;
        cbe_n = ~be;
    endtask : data_ph
endmodule : ptd_master

// ---- tb/pci_target_phase_decode_test.sv ----
// Self-checking bench for the bus phase decoder.
// Assumes the initiator model owns every bus line.
`timescale 1ns/10ps
module pci_target_phase_decode_test;
    logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic frame_n, irdy_n, trdy_n, addr_phase, is_int_ack, is_special, data_valid, in_txn;
    logic [31:0] ad, addr, data, a, d;
    logic [3:0] cbe_n, cmd, byte_en, c, be;
    int mismatches = 0, n_compared = 0, n_ap = 0, n_dv = 0, e_ap = 0;
    initial forever #4 sys_clk = ~sys_clk;
    // Pulses counted mid-cycle, away from the launching edge
    always @(negedge sys_clk) begin
        n_ap += int'(addr_phase === 1'b1);
        n_dv += int'(data_valid === 1'b1);
    end
    ptd_master m (.sys_clk(sys_clk), .ad(ad), .cbe_n(cbe_n), .frame_n(frame_n),
        .irdy_n(irdy_n), .trdy_n(trdy_n));
    ptd_phase_decode uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .ad_in(ad),
        .cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n), .trdy_n(trdy_n),
        .addr_phase(addr_phase), .addr(addr), .cmd(cmd), .is_int_ack(is_int_ack),
        .is_special(is_special), .data_valid(data_valid), .data(data),
        .byte_en(byte_en), .in_txn(in_txn));
    function automatic logic [3:0] lanes(input logic [3:0] x);
        return ~x;
    endfunction : lanes
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic txn(input int w, input bit early, input bit frz);
        // Frozen edges must ignore a frame that is already low
        if (frz) begin
            @(negedge sys_clk);
            clk_en = 1'b0;
        end
        m.addr_ph(a, c);
        if (frz) begin
            chk({addr_phase, in_txn}, 2'h0);
            clk_en = 1'b1;
            @(negedge sys_clk);
        end
        #1;
        e_ap++;
        chk(n_ap, e_ap);
        chk(cmd, c);
        chk({is_int_ack, is_special}, {c == 4'h0, c == 4'h1});
        chk(in_txn, 1'b1);
        m.data_ph(d, be, w, early);
        #1;
        chk(n_dv, e_ap);
        chk(data, d);
        chk(byte_en, lanes(be));
        chk(addr, a);
        chk(in_txn, 1'b0);
    endtask : txn
    initial begin
        void'($urandom(82));
        repeat (10) @(negedge sys_clk);
        chk({addr_phase, data_valid, in_txn, is_int_ack, is_special}, 5'h00);
        chk(cmd, ptd_pkg::CMD_RST);
        chk(byte_en, ptd_pkg::BE_RST);
        chk(addr, ptd_pkg::ADDR_RST);
        chk(data, ptd_pkg::DATA_RST);
        rst = 1'b0;
        for (int i = 0; i < 30; i++) begin
            a = $urandom;
            d = $urandom;
            c = (i < 4) ? i[3:0] : 4'($urandom);
            be = (i < 2) ? 4'(8'h0f >> (4 * i)) : 4'($urandom);
            txn(int'($urandom_range(2)), i[0], (i % 5) == 3);
        end
        report_and_stop();
    end
endmodule : pci_target_phase_decode_test
